/* shared/cce_map.svh */
`ifndef CCE_MAP_SVH
`define CCE_MAP_SVH


// ****************************************
// Mode field codes
// ****************************************
`define CCE_MODE_OFF 4'h0
`define CCE_MODE_FALL 4'h4
`define CCE_MODE_RISE 4'h5
`define CCE_MODE_RISE4 4'h6
`define CCE_MODE_RISE16 4'h7
`define CCE_MODE_SWCMP 4'ha
`define CCE_MODE_SPEVT 4'hb

// ****************************************
// Prescale terminal counts, reset value and synchroniser depth
// ****************************************
`define CCE_PRE4_LAST 4'h3
`define CCE_PRE16_LAST 4'hf
`define CCE_VALUE_RST 16'h0000
`define CCE_SYNC_STAGES 3

`endif

/* shared/cce_pkg.sv */
package cce_pkg;

    typedef logic [3:0] cce_mode_t;
    typedef logic [15:0] cce_count_t;

    // Channel state
    typedef struct packed {
        cce_mode_t mode_prev;
        logic pin_prev;
        logic [3:0] prescale;
        cce_count_t value;
        logic event_flag;
        logic event_request;
        logic match_prev;
        logic special_trigger;
        logic reset_pending;
        logic timer_reset;
        logic conversion_start;
        logic pin_drive_en;
    } cce_state_s;

    // Synchroniser state
    typedef struct packed {
        logic [2:0] stage;
        logic level;
    } cce_sync_s;

endpackage : cce_pkg

/* hw/cce_sync.sv */
`timescale 1ns/1ps
`include "cce_map.svh"

module cce_sync
    import cce_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Asynchronous input and clean level
    input wire logic async_in,
    output logic level
);

    cce_sync_s state;
    cce_sync_s next_state;

    // ****************************************
    // Three stages, level moves when last two agree
    // ****************************************
    always_comb
    begin
        next_state = state;
        next_state.stage = {state.stage[1:0], async_in};
        if (state.stage[1] == state.stage[2])
        begin
            next_state.level = state.stage[2];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign level = state.level;

endmodule : cce_sync

/* hw/cce_unit.sv */
`timescale 1ns/1ps
`include "cce_map.svh"

module cce_unit
    import cce_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Channel pin level as seen at the pad
    input wire logic capture_compare_pin,
    // Shared timer
    input wire logic [15:0] shared_timer_count,
    input wire logic timer_clock_tick,
    output logic timer_reset,
    // Channel control
    input wire logic [3:0] channel_mode_field,
    input wire logic channel_event_enable,
    input wire logic channel_event_flag_clear,
    input wire logic value_write,
    input wire logic [15:0] value_write_data,
    // System state
    input wire logic converter_enable,
    input wire logic sleep_active,
    // Status and results
    output logic [15:0] capture_compare_value_pair,
    output logic channel_event_flag,
    output logic channel_event_request,
    output logic special_trigger,
    output logic conversion_start,
    output logic pin_drive_en
);

    cce_state_s state;
    cce_state_s next_state;
    logic pin_level;

    // ****************************************
    // Pin synchroniser
    // ****************************************
    cce_sync u_pin_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(capture_compare_pin),
        .level(pin_level)
    );

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb
    begin
        logic rise;
        logic fall;
        logic capture_hit;
        logic is_capture;
        logic is_compare;
        logic match;
        logic match_rise;
        logic mode_changed;
        logic set_flag;
        logic is_special;

        rise = 1'b0;
        fall = 1'b0;
        capture_hit = 1'b0;
        is_capture = 1'b0;
        is_compare = 1'b0;
        match = 1'b0;
        match_rise = 1'b0;
        mode_changed = 1'b0;
        set_flag = 1'b0;
        is_special = 1'b0;
        next_state = state;

        // Edge detection on the clean pin level
        rise = pin_level && !state.pin_prev;
        fall = !pin_level && state.pin_prev;
        next_state.pin_prev = pin_level;

        mode_changed = (channel_mode_field != state.mode_prev);
        next_state.mode_prev = channel_mode_field;

        is_capture = (channel_mode_field == `CCE_MODE_FALL)
            || (channel_mode_field == `CCE_MODE_RISE)
            || (channel_mode_field == `CCE_MODE_RISE4)
            || (channel_mode_field == `CCE_MODE_RISE16);
        is_compare = (channel_mode_field == `CCE_MODE_SWCMP)
            || (channel_mode_field == `CCE_MODE_SPEVT);
        is_special = (channel_mode_field == `CCE_MODE_SPEVT);

        // ****************************************
        // Capture event qualification
        // ****************************************
        if (mode_changed)
        begin
            next_state.prescale = 4'h0;
            set_flag = is_capture;
        end
        else
        begin
            unique case (channel_mode_field)
                `CCE_MODE_FALL:
                begin
                    capture_hit = fall;
                end
                `CCE_MODE_RISE:
                begin
                    capture_hit = rise;
                end
                `CCE_MODE_RISE4:
                begin
                    if (rise)
                    begin
                        capture_hit = (state.prescale == `CCE_PRE4_LAST);
                        next_state.prescale = capture_hit ? 4'h0 : state.prescale + 4'h1;
                    end
                end
                `CCE_MODE_RISE16:
                begin
                    if (rise)
                    begin
                        capture_hit = (state.prescale == `CCE_PRE16_LAST);
                        next_state.prescale = state.prescale + 4'h1;
                    end
                end
                default:
                begin
                    capture_hit = 1'b0;
                end
            endcase
        end

        // ****************************************
        // Value pair: capture overwrites, software write loads compare value
        // ****************************************
        if (capture_hit)
        begin
            next_state.value = shared_timer_count;
            set_flag = 1'b1;
        end
        else if (value_write)
        begin
            next_state.value = value_write_data;
        end

        // Compare match, only while the system clock runs
        match = is_compare && !mode_changed && !sleep_active
            && (shared_timer_count == state.value);
        match_rise = match && !state.match_prev;
        next_state.match_prev = match;
        if (match_rise)
        begin
            set_flag = 1'b1;
        end

        // ****************************************
        // Special event trigger
        // ****************************************
        next_state.special_trigger = 1'b0;
        next_state.conversion_start = 1'b0;
        if (match_rise && is_special)
        begin
            next_state.special_trigger = 1'b1;
            next_state.conversion_start = converter_enable;
            next_state.reset_pending = 1'b1;
        end

        // ****************************************
        // Timer reset on the following timer clock edge
        // ****************************************
        next_state.timer_reset = 1'b0;
        if (state.reset_pending && !match)
        begin
            next_state.reset_pending = 1'b0;
        end
        else if (state.reset_pending && timer_clock_tick)
        begin
            next_state.reset_pending = 1'b0;
            next_state.timer_reset = 1'b1;
        end

        // Event flag: hardware set wins over software clear
        if (set_flag)
        begin
            next_state.event_flag = 1'b1;
        end
        else if (channel_event_flag_clear)
        begin
            next_state.event_flag = 1'b0;
        end
        next_state.event_request = next_state.event_flag && channel_event_enable;

        // The channel never drives the pin in these modes
        next_state.pin_drive_en = 1'b0;
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state <= '0;
            state.value <= `CCE_VALUE_RST;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign capture_compare_value_pair = state.value;
    assign channel_event_flag = state.event_flag;
    assign channel_event_request = state.event_request;
    assign special_trigger = state.special_trigger;
    assign conversion_start = state.conversion_start;
    assign timer_reset = state.timer_reset;
    assign pin_drive_en = state.pin_drive_en;

endmodule : cce_unit

/* tb/cce_pin_model.sv */
`timescale 1ns/1ps
module cce_pin_model
(
    // Clock
    input wire logic clk,
    // Pad level
    output logic pin
);
    initial pin = 1'b0;
    // One pad pulse; pin stays an input
    task automatic pulse();
        @(posedge clk);
        #1 pin = 1'b1;
        repeat (8) @(posedge clk);
        #1 pin = 1'b0;
        repeat (8) @(posedge clk);
        #1;
    endtask : pulse
endmodule : cce_pin_model

/* tb/cce_unit_props.sv */
`timescale 1ns/1ps
module cce_unit_props
(
    // Inputs
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [15:0] shared_timer_count,
    input wire logic timer_clock_tick,
    input wire logic [3:0] channel_mode_field,
    input wire logic channel_event_flag_clear,
    input wire logic value_write,
    input wire logic sleep_active,
    // Outputs
    input wire logic timer_reset,
    input wire logic [15:0] capture_compare_value_pair,
    input wire logic channel_event_flag,
    input wire logic special_trigger,
    input wire logic conversion_start,
    input wire logic pin_drive_en
);
    // ***
    // Checks
    // ***
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    wire logic hit_now = shared_timer_count == capture_compare_value_pair;
    trig_pulse_a: assert property (special_trigger |=> !special_trigger)
        else $error("trigger too long");
    trig_match_a: assert property (special_trigger |-> $past(hit_now))
        else $error("trigger without match");
    trig_sleep_a: assert property (special_trigger |-> !$past(sleep_active))
        else $error("trigger in sleep");
    conv_gate_a: assert property (conversion_start |-> special_trigger)
        else $error("stray conversion");
    reset_tick_a: assert property (timer_reset |-> $past(timer_clock_tick) && $past(hit_now))
        else $error("bad timer reset");
    pin_free_a: assert property (!pin_drive_en)
        else $error("pin driven");
    flag_sticky_a: assert property ($fell(channel_event_flag) |-> $past(channel_event_flag_clear))
        else $error("flag lost");
    value_hold_a: assert property ($changed(capture_compare_value_pair) |-> $past(value_write) || channel_event_flag)
        else $error("value changed");
endmodule : cce_unit_props
bind cce_unit cce_unit_props props_i (.clk(clk), .rst_b(rst_b),
    .shared_timer_count(shared_timer_count), .timer_clock_tick(timer_clock_tick),
    .channel_mode_field(channel_mode_field), .channel_event_flag_clear(channel_event_flag_clear),
    .value_write(value_write), .sleep_active(sleep_active), .timer_reset(timer_reset),
    .capture_compare_value_pair(capture_compare_value_pair),
    .channel_event_flag(channel_event_flag), .special_trigger(special_trigger),
    .conversion_start(conversion_start), .pin_drive_en(pin_drive_en));

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    // ***
    // Stimulus and checks
    // ***
    logic clk = 0, rst_b = 0, tick = 0, en = 0, clr = 0, wr = 0, adc = 0, slp = 0;
    logic pin, flag, req, trig, conv, trst, pde, st, cv, tr;
    logic [15:0] cnt = 0, wdat = 0, val, exp_val = 0;
    logic [3:0] mode = 0;
    logic [31:0] rs = 32'hccdf;
    int err_total = 0, tests_run = 0, n;
    int div [4] = '{1, 1, 4, 16};
    always #2.5 clk = ~clk;
    cce_pin_model pm (.clk(clk), .pin(pin));
    cce_unit dut (.clk(clk), .rst_b(rst_b), .capture_compare_pin(pin),
        .shared_timer_count(cnt), .timer_clock_tick(tick), .timer_reset(trst),
        .channel_mode_field(mode), .channel_event_enable(en), .channel_event_flag_clear(clr),
        .value_write(wr), .value_write_data(wdat), .converter_enable(adc),
        .sleep_active(slp), .capture_compare_value_pair(val), .channel_event_flag(flag),
        .channel_event_request(req), .special_trigger(trig), .conversion_start(conv),
        .pin_drive_en(pde));
    function automatic logic [15:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[15:0];
    endfunction : rnd
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        tests_run++;
        if (got !== want)
        begin
            err_total++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, want);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc
    task automatic setmode(input logic [3:0] m);
        mode = m;
        cyc(3);
        clr = 1;
        cyc(1);
        clr = 0;
        cyc(1);
    endtask : setmode
    task automatic load(input logic [15:0] v);
        wdat = v;
        wr = 1;
        cyc(1);
        wr = 0;
    endtask : load
    task automatic hit(input logic [15:0] v);
        cnt = v ^ 16'h1;
        st = 0;
        cv = 0;
        tr = 0;
        for (int k = 0; k < 6; k++)
        begin
            cyc(1);
            if (k == 1)
                cnt = v;
            st |= trig;
            cv |= conv;
            tr |= trst;
        end
    endtask : hit
    task automatic end_sim();
        if (err_total == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    initial
    begin
        #20000;
        err_total++;
        end_sim();
    end
    initial
    begin
        cyc(3);
        rst_b = 1;
        for (int i = 0; i < 4; i++)
        begin
            setmode(4'h4 + i[3:0]);
            for (n = 1; n <= 17; n++)
            begin
                cnt = rnd();
                if (n % div[i] == 0)
                    exp_val = cnt;
                pm.pulse();
                chk(val, exp_val);
                chk(flag, n >= div[i]);
            end
        end
        for (int a = 0; a < 2; a++)
        begin
            adc = a[0];
            setmode(4'hb);
            load(rnd());
            hit(wdat);
            chk(st, 1);
            chk(cv, a);
            tick = 1;
            hit(wdat);
            chk(tr, 1);
            tick = 0;
            hit(wdat);
            chk(st, 1);
            load(~wdat);
            tick = 1;
            hit(~wdat);
            chk(tr, 0);
            tick = 0;
        end
        setmode(4'ha);
        en = 1;
        hit(wdat);
        chk(st, 0);
        chk(flag, 1);
        chk(req, 1);
        en = 0;
        setmode(4'hb);
        slp = 1;
        hit(wdat);
        chk(st, 0);
        end_sim();
    end
endmodule : testbench
